// ---- verilog/dli_pkg.sv ----
// Purpose: shared constants and types for the display list interpreter
// Assumes: byte-wide display list memory, one fetch per request
// Notes:   each action carries the scan lines of its mode line and the display memory address
package dli_pkg;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [3:0] DLI_HI_PLAIN    = 4'h0;
  localparam logic [3:0] DLI_HI_LMS      = 4'h4;
  localparam logic [3:0] DLI_LO_BLANK    = 4'h0;
  localparam logic [7:0] DLI_JUMP_CODE   = 8'h41;
  localparam logic [3:0] DLI_MODE_TEXT20 = 4'h6;
  localparam logic [3:0] DLI_MODE_FIRST  = 4'h2;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int         DLI_ADDR_W      = 16;
  localparam int         DLI_FIFO_DEPTH  = 16;
  localparam logic [15:0] DLI_LIST_RESET = 16'h0000;

  typedef enum {
    DLI_ACT_MODE,
    DLI_ACT_BLANK
  } dli_kind_type;

  // one display action handed downstream
  typedef struct packed {
    logic        blank;
    logic [3:0]  mode;
    logic [4:0]  scan_lines;
    logic [15:0] mem_addr;
  } dli_action_type;

  localparam int DLI_ACTION_W = $bits(dli_action_type);

endpackage

// ---- verilog/dli_fifo.sv ----
// Purpose: small synchronous FIFO between decoder and display engine
// Assumes: single clock, outputs decoded combinationally from count and the stored entries
// Notes:   full and empty are exact; no write when full, no read when empty
`timescale 1ns/10ps
module dli_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_sync_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
      $error("fifo depth must be a power of two, at least 2");
    end
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid && (count != (AW+1)'(DEPTH));
    pop         = out_ready && (count != '0);
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    in_ready    = count != (AW+1)'(DEPTH);
    out_valid   = count != '0;
    out_data    = store[rd_ptr];
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

endmodule

// ---- verilog/dli_decoder.sv ----
// Purpose: walks a display list and emits one action per mode line or blank instruction
// Assumes: memory answers each fetch with rd_valid some cycles later
// Notes:   actions queue in a FIFO; a full FIFO stalls further fetches
//
// Behaviour
// RULE1 - byte with high nibble 0 and a mode code emits one mode line.
// RULE2 - high nibble 4 with mode code emits mode line and reloads pointer.
// RULE3 - two bytes after a reload instruction form new address, low first.
// RULE4 - mode code 6 is the twenty-column text mode.
// RULE5 - instructions handled strictly in list order, one after another.
// RULE6 - jump reads target low then high and resumes fetching there.
// RULE7 - byte 0x41 is the jump instruction.
// RULE8 - low nibble 0, high nibble 0..7 emits background lines only.
// RULE9 - mode code sets the scan line count of its mode line.
// RULE10 - blank emits high nibble plus one background lines.
`timescale 1ns/10ps
module dli_decoder
  import dli_pkg::*;
#(
  parameter int DEPTH = DLI_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  // control
  input  wire logic                  start,
  input  wire logic [DLI_ADDR_W-1:0] list_start,
  // display list memory
  output logic                       rd_req,
  output logic [DLI_ADDR_W-1:0]      rd_addr,
  input  wire logic                  rd_valid,
  input  wire logic [7:0]            rd_data,
  // decoded actions
  output logic                       act_valid,
  input  wire logic                  act_ready,
  output dli_action_type             act_data,
  // status
  output logic                       busy,
  output logic                       list_wrap
);

  initial begin
    if (DEPTH < 2) begin
      $error("action fifo depth too small");
    end
  end

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_n;
  logic rst_sync_n;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // scan lines per mode line, indexed by mode code
  function automatic logic [4:0] mode_lines(input logic [3:0] code);
    case (code)
      4'h2, 4'h4, 4'h6, 4'h8:  mode_lines = 5'd8;
      4'h3:                    mode_lines = 5'd10;
      4'h5, 4'h7:              mode_lines = 5'd16;
      4'h9, 4'hA:              mode_lines = 5'd4;
      4'hB, 4'hD:              mode_lines = 5'd2;
      default:                 mode_lines = 5'd1;
    endcase
  endfunction

  function automatic logic is_mode(input logic [3:0] code);
    is_mode = code >= DLI_MODE_FIRST;
  endfunction

  // ----------------------------------------------------------------
  // fetch and decode state machine
  // ----------------------------------------------------------------
  typedef enum {
    DLI_IDLE,
    DLI_FETCH,
    DLI_WAIT,
    DLI_ARG_LO,
    DLI_WAIT_LO,
    DLI_ARG_HI,
    DLI_WAIT_HI,
    DLI_EMIT
  } dli_state_type;

  dli_state_type             state;
  dli_state_type             next_state;
  logic [DLI_ADDR_W-1:0]     list_ptr;
  logic [DLI_ADDR_W-1:0]     next_list_ptr;
  logic [DLI_ADDR_W-1:0]     display_memory_start;
  logic [DLI_ADDR_W-1:0]     next_display_memory_start;
  logic [7:0]                instr;
  logic [7:0]                next_instr;
  logic [7:0]                arg_lo;
  logic [7:0]                next_arg_lo;
  logic                      next_rd_req;
  logic [DLI_ADDR_W-1:0]     next_rd_addr;
  logic                      next_list_wrap;
  logic                      push;
  logic                      fifo_ready;
  dli_action_type            push_data;
  logic                      is_jump;

  always_comb begin
    next_state                = state;
    next_list_ptr             = list_ptr;
    next_display_memory_start = display_memory_start;
    next_instr                = instr;
    next_arg_lo               = arg_lo;
    next_rd_req               = 1'b0;
    next_rd_addr              = rd_addr;
    next_list_wrap            = 1'b0;
    push                      = 1'b0;
    is_jump                   = instr == DLI_JUMP_CODE;                 // see RULE7
    push_data                 = '0;
    push_data.mem_addr        = display_memory_start;
    if (instr[3:0] == DLI_LO_BLANK) begin                              // see RULE8
      push_data.blank      = 1'b1;
      push_data.scan_lines = {2'b00, instr[6:4]} + 5'd1;               // see RULE10
    end else begin
      push_data.mode       = instr[3:0];                               // see RULE1
      push_data.scan_lines = mode_lines(instr[3:0]);                   // see RULE4, see RULE9
    end
    case (state)
      DLI_IDLE: begin
        if (start) begin
          next_list_ptr = list_start;
          next_state    = DLI_FETCH;
        end
      end
      DLI_FETCH: begin                                                 // see RULE5
        next_rd_req   = 1'b1;
        next_rd_addr  = list_ptr;
        next_list_ptr = list_ptr + 16'd1;
        next_state    = DLI_WAIT;
      end
      DLI_WAIT: begin
        if (rd_valid) begin
          next_instr = rd_data;
          if (rd_data == DLI_JUMP_CODE
              || (rd_data[7:4] == DLI_HI_LMS && is_mode(rd_data[3:0]))) begin
            next_state = DLI_ARG_LO;                                   // see RULE2, see RULE6
          end else if (rd_data[3:0] == DLI_LO_BLANK && !rd_data[7]) begin
            next_state = DLI_EMIT;
          end else if (rd_data[7:4] == DLI_HI_PLAIN && is_mode(rd_data[3:0])) begin
            next_state = DLI_EMIT;
          end else begin
            next_state = DLI_FETCH;
          end
        end
      end
      DLI_ARG_LO: begin                                                // see RULE3
        next_rd_req   = 1'b1;
        next_rd_addr  = list_ptr;
        next_list_ptr = list_ptr + 16'd1;
        next_state    = DLI_WAIT_LO;
      end
      DLI_WAIT_LO: begin
        if (rd_valid) begin
          next_arg_lo = rd_data;
          next_state  = DLI_ARG_HI;
        end
      end
      DLI_ARG_HI: begin
        next_rd_req   = 1'b1;
        next_rd_addr  = list_ptr;
        next_list_ptr = list_ptr + 16'd1;
        next_state    = DLI_WAIT_HI;
      end
      DLI_WAIT_HI: begin
        if (rd_valid) begin
          if (is_jump) begin                                           // see RULE6
            next_list_ptr  = {rd_data, arg_lo};
            next_list_wrap = 1'b1;
            next_state     = DLI_FETCH;
          end else begin                                               // see RULE3
            next_display_memory_start = {rd_data, arg_lo};
            next_state                = DLI_EMIT;
          end
        end
      end
      DLI_EMIT: begin
        if (fifo_ready) begin
          push       = 1'b1;
          next_state = DLI_FETCH;
        end
      end
      default: next_state = DLI_IDLE;
    endcase
    if (state == DLI_EMIT) begin
      push_data.mem_addr = display_memory_start;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state                <= DLI_IDLE;
      list_ptr             <= DLI_LIST_RESET;
      display_memory_start <= DLI_LIST_RESET;
      instr                <= 8'h00;
      arg_lo               <= 8'h00;
      rd_req               <= 1'b0;
      rd_addr              <= DLI_LIST_RESET;
      list_wrap            <= 1'b0;
      busy                 <= 1'b0;
    end else begin
      state                <= next_state;
      list_ptr             <= next_list_ptr;
      display_memory_start <= next_display_memory_start;
      instr                <= next_instr;
      arg_lo               <= next_arg_lo;
      rd_req               <= next_rd_req;
      rd_addr              <= next_rd_addr;
      list_wrap            <= next_list_wrap;
      busy                 <= next_state != DLI_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // action queue
  // ----------------------------------------------------------------
  logic           q_valid;
  dli_action_type q_data;

  dli_fifo #(
    .WIDTH (DLI_ACTION_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_sys    (clk_sys),
    .rst_sync_n (rst_sync_n),
    .in_valid   (push),
    .in_ready   (fifo_ready),
    .in_data    (push_data),
    .out_valid  (q_valid),
    .out_ready  (act_ready && (!act_valid || act_ready)),
    .out_data   (q_data)
  );

  // output register: one-entry stage, loaded only while act_ready is high, so the outputs are flops
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      act_valid <= 1'b0;
      act_data  <= '0;
    end else if (act_ready) begin
      act_valid <= q_valid;
      act_data  <= q_data;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_jump_code;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (state == DLI_WAIT && rd_valid && rd_data == DLI_JUMP_CODE) |=> state == DLI_ARG_LO;
  endproperty
  a_jump_code: assert property (p_jump_code) else $error("jump not decoded"); // see RULE7

  property p_jump_target;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (state == DLI_WAIT_HI && rd_valid && is_jump)
      |=> list_ptr == {$past(rd_data), $past(arg_lo)} ##1 rd_addr == $past(list_ptr);
  endproperty
  a_jump_target: assert property (p_jump_target) else $error("jump target wrong"); // see RULE6

  property p_lms_load;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (state == DLI_WAIT_HI && rd_valid && !is_jump)
      |=> display_memory_start == {$past(rd_data), $past(arg_lo)};
  endproperty
  a_lms_load: assert property (p_lms_load) else $error("pointer reload wrong"); // see RULE3

  property p_lms_emits;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (state == DLI_WAIT && rd_valid && rd_data[7:4] == DLI_HI_LMS && rd_data[3:0] >= 4'h2)
      |=> instr == $past(rd_data)
      ##[4:1000] push && !push_data.blank && push_data.mode == instr[3:0];
  endproperty
  a_lms_emits: assert property (p_lms_emits) else $error("reload line missing"); // see RULE2

  property p_mode_line;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (push && !instr[7] && instr[3:0] >= DLI_MODE_FIRST)
      |-> !push_data.blank && push_data.mode == instr[3:0];
  endproperty
  a_mode_line: assert property (p_mode_line) else $error("mode line wrong"); // see RULE1

  property p_text20;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (push && instr[3:0] == DLI_MODE_TEXT20) |-> push_data.scan_lines == 5'd8;
  endproperty
  a_text20: assert property (p_text20) else $error("text mode lines wrong"); // see RULE4

  property p_blank;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (push && instr[3:0] == DLI_LO_BLANK)
      |-> push_data.blank && push_data.scan_lines == {2'b00, instr[6:4]} + 5'd1;
  endproperty
  a_blank: assert property (p_blank) else $error("blank count wrong"); // see RULE8

  property p_order;
    @(posedge clk_sys) disable iff (!rst_sync_n)
    (rd_req && state == DLI_WAIT && $past(state) == DLI_FETCH)
      |-> rd_addr == list_ptr - 16'd1;
  endproperty
  a_order: assert property (p_order) else $error("fetch out of order"); // see RULE5

endmodule

// ---- verif/dli_mem_model.sv ----
// Purpose: byte memory holding the display list, answers decoder fetches
// Assumes: one fetch outstanding, lat cycles from request to answer, lat >= 1
// Notes:   data bus shows the inverse of the last byte while no answer is up
`timescale 1ns/10ps
module dli_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // fetch side
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic             rd_valid,
  output logic [7:0]       rd_data,
  // answer delay
  input  wire logic [3:0]  lat
);
  logic [7:0] mem [256];
  logic [7:0] last;
  logic [7:0] adr;
  logic [3:0] cnt;

  // ----------------------------------------------------------------
  // answer each request exactly once
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= 4'h0;
      adr      <= 8'h00;
      last     <= 8'h00;
      rd_valid <= 1'b0;
      rd_data  <= 8'hff;
    end else begin
      rd_valid <= 1'b0;
      // released bus must not look like stale data
      rd_data  <= ~last;
      if (rd_req) begin
        cnt <= lat;
        adr <= rd_addr[7:0];
      end else if (cnt == 4'h1) begin
        rd_valid <= 1'b1;
        rd_data  <= mem[adr];
        last     <= mem[adr];
        cnt      <= 4'h0;
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// ---- verif/tb_top.sv ----
// Purpose: self-checking bench for the display list decoder
// Assumes: memory model on the fetch side, bench acts as action consumer
// Notes:   pointer advance after mode lines is not judged, only reloads
`timescale 1ns/10ps
module tb_top;
  import dli_pkg::*;

  logic           clk_sys;
  logic           rst_n;
  logic           start;
  logic [15:0]    list_start;
  logic           rd_req;
  logic [15:0]    rd_addr;
  logic           rd_valid;
  logic [7:0]     rd_data;
  logic           act_valid;
  logic           act_ready;
  dli_action_type act_data;
  logic           busy;
  logic           list_wrap;
  logic [3:0]     lat;
  logic [15:0]    wrap_addr;
  logic           wrapped;
  logic           wgot;
  dli_action_type got [$];
  int             fail_count;
  int             n_tests;
  int             n_req;

  dli_decoder i_dli_decoder (
    .clk_sys(clk_sys), .rst_n(rst_n), .start(start), .list_start(list_start),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_data(rd_data),
    .act_valid(act_valid), .act_ready(act_ready), .act_data(act_data),
    .busy(busy), .list_wrap(list_wrap)
  );

  dli_mem_model i_dli_mem_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_valid(rd_valid), .rd_data(rd_data), .lat(lat)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // monitor: accepted actions, fetch count, first fetch after a wrap
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (act_valid === 1'b1 && act_ready === 1'b1) got.push_back(act_data);
    if (list_wrap === 1'b1) wrapped = 1'b1;
    if (rd_req === 1'b1) begin
      n_req++;
      if (wrapped && !wgot) begin
        wrap_addr = rd_addr;
        wgot      = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic int slines(input int m);
    case (m)
      2, 4, 6, 8: return 8;
      3:          return 10;
      5, 7:       return 16;
      9, 10:      return 4;
      11, 13:     return 2;
      default:    return 1;
    endcase
  endfunction

  task automatic do_reset();
    @(negedge clk_sys);
    rst_n = 1'b0;
    got.delete();
    n_req   = 0;
    wrapped = 1'b0;
    wgot    = 1'b0;
    repeat (16) @(negedge clk_sys);
    check({busy, act_valid, rd_req}, 0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic start_list(input logic [15:0] a);
    @(negedge clk_sys);
    start      = 1'b1;
    list_start = a;
    @(negedge clk_sys);
    start = 1'b0;
  endtask

  task automatic wait_got();
    for (int k = 0; k < 3000 && got.size() < 26; k++) @(negedge clk_sys);
  endtask

  // list: reload, modes 2..F, two bad bytes, eight blanks, jump to 0x80
  task automatic load_list();
    for (int a = 3; a < 17; a++) i_dli_mem_model.mem[a] = 8'(a - 1);
    for (int a = 19; a < 27; a++) i_dli_mem_model.mem[a] = 8'((a - 19) << 4);
    i_dli_mem_model.mem[0]  = 8'h46;
    i_dli_mem_model.mem[1]  = 8'h34;
    i_dli_mem_model.mem[2]  = 8'h12;
    i_dli_mem_model.mem[17] = 8'h01;
    i_dli_mem_model.mem[18] = 8'h85;
    i_dli_mem_model.mem[27] = 8'h41;
    i_dli_mem_model.mem[28] = 8'h80;
    i_dli_mem_model.mem[29] = 8'h00;
    i_dli_mem_model.mem[8'h80] = 8'h42;
    i_dli_mem_model.mem[8'h81] = 8'h78;
    i_dli_mem_model.mem[8'h82] = 8'h56;
    i_dli_mem_model.mem[8'h83] = 8'h41;
    i_dli_mem_model.mem[8'h84] = 8'h80;
    i_dli_mem_model.mem[8'h85] = 8'h00;
  endtask

  task automatic cmp_all();
    int m;
    logic b;
    check(32'(got.size() >= 26), 1);
    for (int i = 0; i < 26 && i < got.size(); i++) begin
      b = (i >= 15 && i <= 22);
      m = (i == 0) ? 6 : (i <= 14) ? i + 1 : 2;
      check(got[i].blank, b);
      if (b) check(got[i].scan_lines, i - 14);
      else check({got[i].mode, got[i].scan_lines}, {m[3:0], 5'(slines(m))});
      if (i >= 23) check(got[i].mem_addr, 16'h5678);
    end
    check(got[0].mode, 4'h6);
    check(got[0].mem_addr, 16'h1234);
    check({wgot, wrap_addr}, {1'b1, 16'h0080});
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_walk();
    do_reset();
    lat       = 4'h1;
    act_ready = 1'b1;
    start_list(16'h0000);
    wait_got();
    cmp_all();
  endtask

  // consumer stalls: fifo fills, fetching stops, a second start is ignored
  task automatic t_stall();
    int n0;
    do_reset();
    lat       = 4'h3;
    act_ready = 1'b0;
    start_list(16'h0000);
    repeat (300) @(negedge clk_sys);
    n0 = n_req;
    check(busy, 1);
    start_list(16'h0080);
    repeat (100) @(negedge clk_sys);
    check(n_req, n0);
    check(got.size(), 0);
    act_ready = 1'b1;
    wait_got();
    cmp_all();
  endtask

  initial begin
    rst_n      = 1'b0;
    start      = 1'b0;
    list_start = 16'h0000;
    act_ready  = 1'b0;
    lat        = 4'h1;
    fail_count = 0;
    n_tests    = 0;
    load_list();
    t_walk();
    t_stall();
    give_verdict();
  end

  initial begin
    #(8 * 20000);
    fail_count++;
    give_verdict();
  end
endmodule
